// file: design/motor_loop_config_regs.sv
// Startup and closed-loop configuration registers with applied settings
`default_nettype none

// Overview of operation
// - Startup bits 17-13 hold stage-two open-loop acceleration
// - Code 1Fh means no limit, value 32767
// - Bits 5-2 set minimum duty; clamp duty
// - Closed-loop word at 86h, resets to zero
// - Bits 30-29 choose fixed or variable commutation
// - Bits 28-24 hold closed-loop acceleration rate
// - Bit 23 picks deceleration source field
// - Bits 22-18 hold closed-loop deceleration rate
module motor_loop_config_regs
   import motor_cfg_pkg::*;
(
   input  wire logic              clk,            // System clock
   input  wire logic              srst,           // Synchronous reset
   input  wire logic              ce,             // Clock enable
   input  wire logic [7:0]        reg_addr,       // Register address
   input  wire logic              reg_wr,         // Write strobe
   input  wire logic              reg_rd,         // Read strobe
   input  wire logic [31:0]       reg_wdata,      // Write data
   output logic      [31:0]       reg_rdata,      // Read data
   output logic                   reg_rvalid,     // Read data valid pulse
   input  wire logic              ramp_busy,      // A ramp is running
   input  wire logic              ramp_step,      // Ramp step boundary
   input  wire logic [DUTY_W-1:0] duty_cmd,       // Requested duty, 0.1 %
   output logic      [DUTY_W-1:0] duty_out,       // Clamped duty, 0.1 %
   output logic      [RATE_W-1:0] ol_accel_rate,  // Stage-two accel rate
   output logic      [RATE_W-1:0] cl_accel_rate,  // Closed-loop accel rate
   output logic      [RATE_W-1:0] cl_decel_rate,  // Closed-loop decel rate
   output logic                   comm_variable,  // Variable 120-150 mode
   output logic                   comm_undefined, // Undefined mode code
   output logic                   decel_from_acc  // Decel uses accel rate
);

   typedef struct packed {
      logic [31:0]            startup_q;
      logic [31:0]            closed_q;
      logic [31:0]            rdata;
      logic                   rvalid;
      logic [RATE_CODE_W-1:0] ol_code;
      logic [RATE_CODE_W-1:0] cla_code;
      logic [RATE_CODE_W-1:0] cld_code;
      logic                   dec_src;
      logic                   comm_var;
      logic                   comm_undef;
      logic [DUTY_W-1:0]      duty;
   } regs_s;

   regs_s st_q;
   regs_s st_d;

   logic [RATE_CODE_W-1:0] rate_code [RATE_CHANNELS];
   logic [RATE_W-1:0]      rate_val  [RATE_CHANNELS];

   // Rate codes and decel source apply only between ramps or on a step boundary; duty floor and commutation apply at once
   logic                   apply_ok;
   logic [DUTY_W-1:0]      min_duty;
   comm_mode_e             comm_mode;

   assign apply_ok  = !ramp_busy || ramp_step;
   assign min_duty  =
      MIN_DUTY_TABLE[st_q.startup_q[MIN_DUTY_MSB:MIN_DUTY_LSB]];
   assign comm_mode = comm_mode_e'(st_q.closed_q[COMM_MSB:COMM_LSB]);

   always_comb
   begin
      st_d        = st_q;
      st_d.rvalid = 1'b0;

      // Whole words stored so read-back is exact
      if (reg_wr)
      begin
         if (reg_addr == STARTUP_TWO_ADDR)
         begin
            st_d.startup_q = reg_wdata;
         end
         if (reg_addr == CLOSED_ONE_ADDR)
         begin
            st_d.closed_q = reg_wdata;
         end
      end

      // Unmapped addresses read as zero
      if (reg_rd)
      begin
         st_d.rvalid = 1'b1;
         if (reg_addr == STARTUP_TWO_ADDR)
         begin
            st_d.rdata = st_q.startup_q;
         end
         else if (reg_addr == CLOSED_ONE_ADDR)
         begin
            st_d.rdata = st_q.closed_q;
         end
         else
         begin
            st_d.rdata = READ_ZERO;
         end
      end

      // Rate codes move to the ramp only at a safe point
      if (apply_ok)
      begin
         st_d.ol_code  = st_q.startup_q[OL_ACC2_MSB:OL_ACC2_LSB];
         st_d.cla_code = st_q.closed_q[CLOSEDLOOP_ACCEL_RATE_MSB:CLOSEDLOOP_ACCEL_RATE_LSB];
         st_d.dec_src  = st_q.closed_q[DEC_SRC_BIT];
         if (st_q.closed_q[DEC_SRC_BIT])
         begin
            st_d.cld_code = st_q.closed_q[CLOSEDLOOP_ACCEL_RATE_MSB:CLOSEDLOOP_ACCEL_RATE_LSB];
         end
         else
         begin
            st_d.cld_code = st_q.closed_q[CLOSEDLOOP_DECEL_RATE_MSB:CLOSEDLOOP_DECEL_RATE_LSB];
         end
      end

      // Undefined commutation codes clear comm_var, as fixed 120 degrees does, and set comm_undef
      case (comm_mode)
         COMM_FIXED_120:
         begin
            st_d.comm_var   = 1'b0;
            st_d.comm_undef = 1'b0;
         end
         COMM_VAR_120_150:
         begin
            st_d.comm_var   = 1'b1;
            st_d.comm_undef = 1'b0;
         end
         default:
         begin
            st_d.comm_var   = 1'b0;
            st_d.comm_undef = 1'b1;
         end
      endcase

      // Duty never goes below the selected minimum
      if (duty_cmd < min_duty)
      begin
         st_d.duty = min_duty;
      end
      else
      begin
         st_d.duty = duty_cmd;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         st_q.startup_q  <= STARTUP_TWO_RST;
         st_q.closed_q   <= CLOSED_ONE_RST;
         st_q.rdata      <= READ_ZERO;
         st_q.rvalid     <= 1'b0;
         st_q.ol_code    <= RATE_CODE_RST;
         st_q.cla_code   <= RATE_CODE_RST;
         st_q.cld_code   <= RATE_CODE_RST;
         st_q.dec_src    <= 1'b0;
         st_q.comm_var   <= 1'b0;
         st_q.comm_undef <= 1'b0;
         st_q.duty       <= DUTY_RST;
      end
      else if (ce)
      begin
         st_q <= st_d;
      end
   end

   assign rate_code[0] = st_q.ol_code;
   assign rate_code[1] = st_q.cla_code;
   assign rate_code[2] = st_q.cld_code;

   // One ladder per rate channel; 1Fh gives the saturated value
   for (genvar i = 0; i < RATE_CHANNELS; i++)
   begin : g_ladder
      rate_ladder u_ladder (
         .clk  (clk),
         .srst (srst),
         .ce   (ce),
         .code (rate_code[i]),
         .rate (rate_val[i])
      );
   end

   assign ol_accel_rate  = rate_val[0];
   assign cl_accel_rate  = rate_val[1];
   assign cl_decel_rate  = rate_val[2];
   assign reg_rdata      = st_q.rdata;
   assign reg_rvalid     = st_q.rvalid;
   assign duty_out       = st_q.duty;
   assign comm_variable  = st_q.comm_var;
   assign comm_undefined = st_q.comm_undef;
   assign decel_from_acc = st_q.dec_src;

endmodule : motor_loop_config_regs

`default_nettype wire

// file: design/motor_cfg_pkg.sv
// Package: addresses, field layout, reset values and lookup ladders
`default_nettype none

package motor_cfg_pkg;

   // Register addresses on the configuration port
   localparam logic [7:0]  STARTUP_TWO_ADDR  = 8'h80;
   localparam logic [7:0]  CLOSED_ONE_ADDR   = 8'h86;

   // Values after reset
   localparam logic [31:0] STARTUP_TWO_RST   = 32'h0000_0000;
   localparam logic [31:0] CLOSED_ONE_RST    = 32'h0000_0000;
   localparam logic [31:0] READ_ZERO         = 32'h0000_0000;

   // Field positions in the startup word
   localparam int          OL_ACC2_MSB       = 17;
   localparam int          OL_ACC2_LSB       = 13;
   localparam int          MIN_DUTY_MSB      = 5;
   localparam int          MIN_DUTY_LSB      = 2;

   // Field positions in the closed-loop word
   localparam int          COMM_MSB          = 30;
   localparam int          COMM_LSB          = 29;
   localparam int          CLOSEDLOOP_ACCEL_RATE_MSB        = 28;
   localparam int          CLOSEDLOOP_ACCEL_RATE_LSB        = 24;
   localparam int          DEC_SRC_BIT       = 23;
   localparam int          CLOSEDLOOP_DECEL_RATE_MSB        = 22;
   localparam int          CLOSEDLOOP_DECEL_RATE_LSB        = 18;

   // Widths
   localparam int          RATE_CODE_W       = 5;
   localparam int          RATE_W            = 25;
   localparam int          DUTY_CODE_W       = 4;
   localparam int          DUTY_W            = 10;
   localparam int          RATE_CHANNELS     = 3;

   // Reset values of applied codes and outputs
   localparam logic [RATE_CODE_W-1:0] RATE_CODE_RST = 5'h00;
   localparam logic [RATE_W-1:0]      RATE_RST      = 25'h0000000;
   localparam logic [DUTY_W-1:0]      DUTY_RST      = 10'h000;

   // Rate ladder in thousandths of a unit (Hz/s2 or V/s); last is no limit
   localparam logic [RATE_W-1:0] RATE_NO_LIMIT = 25'd32767000;
   localparam logic [RATE_W-1:0] RATE_LADDER [0:31] = '{
      25'd5,       25'd10,      25'd25,      25'd50,
      25'd100,     25'd250,     25'd500,     25'd1000,
      25'd2500,    25'd5000,    25'd7500,    25'd10000,
      25'd12500,   25'd15000,   25'd20000,   25'd30000,
      25'd40000,   25'd50000,   25'd60000,   25'd75000,
      25'd100000,  25'd125000,  25'd150000,  25'd175000,
      25'd200000,  25'd250000,  25'd300000,  25'd400000,
      25'd500000,  25'd750000,  25'd1000000, RATE_NO_LIMIT
   };

   // Minimum duty ladder in tenths of a percent
   localparam logic [DUTY_W-1:0] MIN_DUTY_TABLE [0:15] = '{
      10'd15,  10'd20,  10'd30,  10'd40,
      10'd50,  10'd60,  10'd70,  10'd80,
      10'd90,  10'd100, 10'd120, 10'd150,
      10'd175, 10'd200, 10'd250, 10'd300
   };

   typedef enum logic [1:0] {
      COMM_FIXED_120   = 2'b00,
      COMM_VAR_120_150 = 2'b01,
      COMM_UNDEF_2     = 2'b10,
      COMM_UNDEF_3     = 2'b11
   } comm_mode_e;

endpackage : motor_cfg_pkg

`default_nettype wire

// file: design/rate_ladder.sv
// Registered lookup of a 5-bit rate code onto the rate ladder
`default_nettype none

module rate_ladder
   import motor_cfg_pkg::*;
(
   input  wire logic                   clk,   // System clock
   input  wire logic                   srst,  // Synchronous reset
   input  wire logic                   ce,    // Clock enable
   input  wire logic [RATE_CODE_W-1:0] code,  // Rate code
   output logic      [RATE_W-1:0]      rate   // Rate in thousandths
);

   typedef struct packed {
      logic [RATE_W-1:0] rate;
   } ladder_s;

   ladder_s st_q;
   ladder_s st_d;

   always_comb
   begin
      st_d = st_q;
      // Codes up to 1Eh are finite; 1Fh saturates
      st_d.rate = RATE_LADDER[code];
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         st_q.rate <= RATE_RST;
      end
      else if (ce)
      begin
         st_q <= st_d;
      end
   end

   assign rate = st_q.rate;

endmodule : rate_ladder

`default_nettype wire

// file: dv/motor_loop_config_chk.sv
// Port-level assertions for the motor loop configuration registers
`default_nettype none

module motor_loop_config_chk
   import motor_cfg_pkg::*;
(
   input wire logic              clk,            // Clock
   input wire logic              srst,           // Reset
   input wire logic              ce,             // Enable
   input wire logic [7:0]        reg_addr,       // Address
   input wire logic              reg_rd,         // Read strobe
   input wire logic [31:0]       reg_rdata,      // Read data
   input wire logic              reg_rvalid,     // Read valid
   input wire logic              ramp_busy,      // Ramp running
   input wire logic              ramp_step,      // Step boundary
   input wire logic [DUTY_W-1:0] duty_cmd,       // Duty request
   input wire logic [DUTY_W-1:0] duty_out,       // Clamped duty
   input wire logic [RATE_W-1:0] ol_accel_rate,  // Open-loop rate
   input wire logic [RATE_W-1:0] cl_accel_rate,  // Accel rate
   input wire logic [RATE_W-1:0] cl_decel_rate,  // Decel rate
   input wire logic              comm_variable,  // Variable mode
   input wire logic              comm_undefined, // Undefined code
   input wire logic              decel_from_acc  // Decel source
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   logic blk;
   assign blk = ce && ramp_busy && !ramp_step;

   // Two edges in a row with applying held off
   sequence s_blocked2;
      blk [*2];
   endsequence

   a_rvalid_delay: assert property (ce && reg_rd |=> reg_rvalid)
      else $error("read not answered on next cycle");
   a_rvalid_match: assert property ($past(ce) && !$past(srst)
      |-> reg_rvalid == $past(reg_rd))
      else $error("read valid without a read");
   a_unmapped_zero: assert property (ce && reg_rd
      && reg_addr != STARTUP_TWO_ADDR && reg_addr != CLOSED_ONE_ADDR
      |=> reg_rdata == READ_ZERO)
      else $error("unmapped read not zero");
   a_duty_floor: assert property (ce |=> duty_out >= $past(duty_cmd)
      && duty_out >= MIN_DUTY_TABLE[0])
      else $error("duty below request or floor");
   a_comm_excl: assert property (!(comm_variable && comm_undefined))
      else $error("both commutation flags set");
   a_rate_hold: assert property (s_blocked2
      |=> $stable(cl_accel_rate) && $stable(cl_decel_rate)
      && $stable(ol_accel_rate))
      else $error("rate changed during ramp");
   a_src_hold: assert property (blk |=> $stable(decel_from_acc))
      else $error("decel source changed during ramp");
   a_decel_follow: assert property (decel_from_acc && ce
      |=> cl_decel_rate == cl_accel_rate)
      else $error("decel rate not from accel code");
   a_rst_clear: assert property (disable iff (1'b0) srst
      |=> !reg_rvalid && !comm_variable && !decel_from_acc
      && duty_out == DUTY_RST)
      else $error("outputs not cleared by reset");
endmodule : motor_loop_config_chk

bind motor_loop_config_regs motor_loop_config_chk u_chk (.clk, .srst, .ce,
   .reg_addr, .reg_rd, .reg_rdata, .reg_rvalid, .ramp_busy, .ramp_step,
   .duty_cmd, .duty_out, .ol_accel_rate, .cl_accel_rate, .cl_decel_rate,
   .comm_variable, .comm_undefined, .decel_from_acc);

`default_nettype wire

// file: dv/tb.sv
// Self-checking bench for the motor loop configuration registers
`default_nettype none

module tb
   import motor_cfg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic              clk = 0, srst = 1, ce = 1, reg_wr = 0, reg_rd = 0;
   logic              ramp_busy = 0, ramp_step = 0, reg_rvalid;
   logic              comm_variable, comm_undefined, decel_from_acc;
   logic [7:0]        reg_addr = 8'h00;
   logic [31:0]       reg_wdata = 32'h0, reg_rdata, sw, cw, q[$];
   logic [DUTY_W-1:0] duty_cmd = 10'h000, duty_out, exp_d;
   logic [RATE_W-1:0] ol_accel_rate, cl_accel_rate, cl_decel_rate;
   int                n_errors = 0, samples_checked = 0;

   always #10 clk = ~clk;

   motor_loop_config_regs u_dut (.clk, .srst, .ce, .reg_addr, .reg_wr,
      .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid, .ramp_busy, .ramp_step,
      .duty_cmd, .duty_out, .ol_accel_rate, .cl_accel_rate, .cl_decel_rate,
      .comm_variable, .comm_undefined, .decel_from_acc);

   task automatic cyc;
      @(posedge clk);
      #1;
   endtask : cyc

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Write when w is set, else read and queue d as the expected data
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      reg_addr = a;
      reg_wdata = w ? d : $urandom;
      reg_wr = w;
      reg_rd = !w;
      if (!w && ce)
         q.push_back(d);
      cyc;
      reg_wr = 0;
      reg_rd = 0;
      cyc;
   endtask : bus

   task automatic close_out;
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : close_out

   always @(posedge clk)
   begin
      if (reg_rvalid === 1'b1)
      begin
         // A read answer with nothing expected counts as a mismatch
         if (q.size() > 0)
            chk(reg_rdata, q.pop_front());
         else
            chk(reg_rvalid, 1'b0);
      end
   end

   initial
   begin
      #100us;
      n_errors++;
      close_out;
   end

   initial
   begin
      void'($urandom(37760));
      repeat (3) cyc;
      srst = 0;
      bus(0, STARTUP_TWO_ADDR, STARTUP_TWO_RST);
      bus(0, CLOSED_ONE_ADDR, CLOSED_ONE_RST);
      bus(0, 8'h84, READ_ZERO);
      $display("reset values done");
      repeat (8)
      begin
         sw = $urandom;
         cw = $urandom;
         bus(1, STARTUP_TWO_ADDR, sw);
         bus(1, CLOSED_ONE_ADDR, cw);
         bus(1, 8'h84, ~sw);
         bus(0, STARTUP_TWO_ADDR, sw);
         bus(0, CLOSED_ONE_ADDR, cw);
      end
      ce = 0;
      bus(1, CLOSED_ONE_ADDR, ~cw);
      ce = 1;
      bus(0, CLOSED_ONE_ADDR, cw);
      $display("readback done");
      for (int k = 0; k < 32; k++)
      begin
         cw = {1'b0, 2'b00, k[4:0], k[0], ~k[4:0], 18'h0};
         bus(1, STARTUP_TWO_ADDR, 32'(k) << OL_ACC2_LSB);
         bus(1, CLOSED_ONE_ADDR, cw);
         repeat (2) cyc;
         chk(ol_accel_rate, RATE_LADDER[k]);
         chk(cl_accel_rate, RATE_LADDER[k]);
         chk(cl_decel_rate, RATE_LADDER[k[0] ? k : 31 - k]);
         chk(decel_from_acc, k[0]);
      end
      chk(ol_accel_rate, 25'd32767000);
      $display("rate ladders done");
      for (int m = 0; m < 4; m++)
      begin
         bus(1, CLOSED_ONE_ADDR, 32'(m) << COMM_LSB);
         chk(comm_variable, m == 1);
         chk(comm_undefined, m > 1);
      end
      $display("commutation done");
      for (int m = 0; m < 16; m++)
      begin
         bus(1, STARTUP_TWO_ADDR, 32'(m) << MIN_DUTY_LSB);
         duty_cmd = 10'($urandom_range(320));
         exp_d = MIN_DUTY_TABLE[m];
         if (duty_cmd > exp_d)
            exp_d = duty_cmd;
         cyc;
         chk(duty_out, exp_d);
      end
      $display("minimum duty done");
      ramp_busy = 1;
      bus(1, CLOSED_ONE_ADDR, 32'h1f00_0000);
      repeat (3) cyc;
      chk(cl_accel_rate, RATE_LADDER[0]);
      ramp_step = 1;
      cyc;
      ramp_step = 0;
      repeat (2) cyc;
      chk(cl_accel_rate, RATE_NO_LIMIT);
      ramp_busy = 0;
      $display("ramp gating done");
      srst = 1;
      cyc;
      srst = 0;
      bus(0, STARTUP_TWO_ADDR, STARTUP_TWO_RST);
      bus(0, CLOSED_ONE_ADDR, CLOSED_ONE_RST);
      $display("second reset done");
      repeat (2) cyc;
      // Every queued read must have been answered by now
      chk(32'(q.size()), 32'h0);
      close_out;
   end
endmodule : tb

`default_nettype wire
